// ===== core/lane_cfg_pkg.sv
// Constants shared by the port and lane configuration block and its parameter store.
// Assumes a single 25 MHz clock and a serial loader that presents one register word per request.
package lane_cfg_pkg;

  localparam int NUM_LANES = 12;
  localparam int NUM_PORTS = 16;
  localparam int WORDS_PER_PORT = 4;
  localparam int MEM_DEPTH = NUM_PORTS * WORDS_PER_PORT;
  localparam int MEM_AW = 6;

  // Strap codes for the port arrangement.
  localparam logic [1:0] ARR_NINE = 2'h0;
  localparam logic [1:0] ARR_SIX = 2'h1;
  localparam logic [1:0] ARR_FIVE = 2'h2;
  localparam logic [1:0] ARR_RESERVED = 2'h3;

  // Per-port register offsets.
  localparam logic [11:0] OFF_DEEMPH_BASE = 12'h854;
  localparam logic [11:0] OFF_RX_TX_CTRL = 12'h858;
  localparam logic [11:0] OFF_AMP_BASE = 12'h8b0;
  localparam logic [11:0] OFF_DRIVE_OFFSET = 12'h8b4;

  // Word slot of each register inside one port's group.
  localparam logic [1:0] SLOT_DEEMPH = 2'h0;
  localparam logic [1:0] SLOT_CTRL = 2'h1;
  localparam logic [1:0] SLOT_AMP = 2'h2;
  localparam logic [1:0] SLOT_OFFSET = 2'h3;

  // Field positions.
  localparam int RXDET_LSB = 4;
  localparam int SIGDET_LSB = 20;
  localparam int EQ_A_LSB = 22;
  localparam int EQ_B_LSB = 26;
  localparam int SWING_BIT = 30;
  localparam int LVL_LSB_0 = 16;
  localparam int LVL_LSB_1 = 21;
  localparam int LVL_LSB_2 = 26;
  localparam int AMP_OFF_LSB = 0;
  localparam int DEEMPH_OFF_LSB = 8;

  // Reset values: recommended receiver settings, full swing, zero levels.
  localparam logic [31:0] RST_DEEMPH_BASE = 32'h0000_0000;
  localparam logic [31:0] RST_RX_TX_CTRL = 32'h0010_0020;
  localparam logic [31:0] RST_AMP_BASE = 32'h0000_0000;
  localparam logic [31:0] RST_DRIVE_OFFSET = 32'h0000_0000;

  // Legal receive equalizer codes.
  localparam logic [3:0] EQ_OFF = 4'h0;
  localparam logic [3:0] EQ_LOW = 4'h2;
  localparam logic [3:0] EQ_MED = 4'h6;
  localparam logic [3:0] EQ_HIGH = 4'he;

  // Drive level limits in level steps.
  localparam logic [5:0] AMP_MAX_CODE = 6'h13;
  localparam logic [5:0] DEEMPH_MAX_CODE = 6'h1f;

  // Receiver-detect wait times and their cycle counts at the 25 MHz clock.
  localparam int CLK_PERIOD_NS = 40;
  localparam int RXDET_T0_NS = 1000;
  localparam int RXDET_T1_NS = 2000;
  localparam int RXDET_T2_NS = 4000;
  localparam int RXDET_T3_NS = 5000;
  localparam int RXDET_T4_NS = 7000;
  localparam logic [7:0] RXDET_C0 = 8'((RXDET_T0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RXDET_C1 = 8'((RXDET_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RXDET_C2 = 8'((RXDET_T2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RXDET_C3 = 8'((RXDET_T3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RXDET_C4 = 8'((RXDET_T4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Which loader presents a request.
  typedef enum logic [1:0] {
    src_eeprom,
    src_smbus,
    src_i2c,
    src_none
  } load_src_t;

endpackage : lane_cfg_pkg

// ===== core/pcie_switch_port_lane_config.sv
// Port arrangement, lane-to-port binding, port-good decode and per-lane PHY settings.
// Assumes straps are stable during reset and a serial loader issues one word request at a time.
//
// Notes on behaviour
// R1 - Strap 00 nine, 01 six, 10 five ports.
// R2 - Lane n uses transmit and receive pair n.
// R3 - Nine-port lane to port binding.
// R4 - Six-port lane to port binding.
// R5 - Five-port lane to port binding.
// R6 - Port 0 upstream, all others downstream.
// R7 - Nine-port: port-good bit n means port n.
// R8 - Six-port: bits 10, 12, 14 unused.
// R9 - Five-port: bits 11, 13 serve ports 7, 9.
// R10 - Each lane has its own control signal set.
// R11 - Drive and equalizer settable per channel via loaders.
// R12 - Full swing always applies -3.5 dB de-emphasis; here lane_gen2 selects the bits 25:21 de-emphasis field instead.
// R13 - Receiver-detect wait from 0x858 bits 6:4.
// R14 - Signal-detect threshold from 0x858 bits 21:20.
// R15 - Receive equalizer from 0x858 bits 25:22, 29:26.
// R16 - Bit 30: 0 full swing, 1 half swing.
// R17 - Swing picks one amplitude, one de-emphasis field; here swing picks the amplitude field and lane_gen2 picks the de-emphasis field.
// R18 - Drive offsets writable from EEPROM only.
// R19 - Final level is base plus offset steps.
// R20 - Straps sampled in reset, held until next reset; here only the arrangement is, port_ok_q tracks port_ok_strap_n.
`timescale 1ns/1ps
module pcie_switch_port_lane_config (
  clk,
  reset_n,
  port_arrangement_strap,
  port_ok_strap_n,
  lane_gen2,
  cfg_wr,
  cfg_rd,
  cfg_src,
  cfg_port,
  cfg_addr,
  cfg_wdata,
  cfg_rdata_q,
  cfg_rvalid_q,
  cfg_err_q,
  arrangement_q,
  arrangement_reserved_q,
  port_ok_q,
  pair_enable_q,
  lane_port_q,
  lane_upstream_q,
  lane_rxdet_cycles_q,
  lane_sigdet_q,
  lane_eq_a_q,
  lane_eq_b_q,
  lane_half_swing_q,
  lane_amp_q,
  lane_deemph_q
);
  input wire logic clk;
  input wire logic reset_n;
  input wire logic [1:0] port_arrangement_strap;
  input wire logic [15:0] port_ok_strap_n;
  input wire logic [11:0] lane_gen2;
  input wire logic cfg_wr;
  input wire logic cfg_rd;
  input wire lane_cfg_pkg::load_src_t cfg_src;
  input wire logic [3:0] cfg_port;
  input wire logic [11:0] cfg_addr;
  input wire logic [31:0] cfg_wdata;
  output logic [31:0] cfg_rdata_q;
  output logic cfg_rvalid_q;
  output logic cfg_err_q;
  output logic [1:0] arrangement_q;
  output logic arrangement_reserved_q;
  output logic [15:0] port_ok_q;
  output logic [11:0] pair_enable_q;
  output logic [47:0] lane_port_q;
  output logic [11:0] lane_upstream_q;
  output logic [95:0] lane_rxdet_cycles_q;
  output logic [23:0] lane_sigdet_q;
  output logic [47:0] lane_eq_a_q;
  output logic [47:0] lane_eq_b_q;
  output logic [11:0] lane_half_swing_q;
  output logic [59:0] lane_amp_q;
  output logic [59:0] lane_deemph_q;

  // Port owning a lane in a given arrangement.
  function automatic logic [3:0] lane_to_port(input logic [1:0] arr, input logic [3:0] lane);
    lane_to_port = 4'h0;
    if (lane > 4'h3) begin
      unique case (arr)
        lane_cfg_pkg::ARR_NINE: begin
          unique case (lane)
            4'h4: lane_to_port = 4'h2; // see R3
            4'h5: lane_to_port = 4'ha;
            4'h6: lane_to_port = 4'hc;
            4'h7: lane_to_port = 4'he;
            4'h8: lane_to_port = 4'h3;
            4'h9: lane_to_port = 4'hb;
            4'ha: lane_to_port = 4'hd;
            default: lane_to_port = 4'hf;
          endcase
        end
        lane_cfg_pkg::ARR_SIX: begin
          unique case (lane)
            4'h8: lane_to_port = 4'h3; // see R4
            4'h9: lane_to_port = 4'hb;
            4'ha: lane_to_port = 4'hd;
            4'hb: lane_to_port = 4'hf;
            default: lane_to_port = 4'h2;
          endcase
        end
        lane_cfg_pkg::ARR_FIVE: begin
          unique case (lane)
            4'h4, 4'h5: lane_to_port = 4'h2; // see R5
            4'h6, 4'h7: lane_to_port = 4'h7;
            4'h8, 4'h9: lane_to_port = 4'h3;
            default: lane_to_port = 4'h9;
          endcase
        end
        default: lane_to_port = 4'h0;
      endcase
    end
  endfunction : lane_to_port

  // Port fed by a port-good strap bit, with a flag for an unused bit.
  function automatic logic [4:0] strap_bit_to_port(input logic [1:0] arr, input logic [3:0] bitn);
    logic [4:0] r;
    r = 5'h00;
    unique case (bitn)
      4'h0, 4'h2, 4'h3: r = {1'b1, bitn};
      4'ha, 4'hc, 4'he: r = (arr == lane_cfg_pkg::ARR_NINE) ? {1'b1, bitn} : 5'h00; // see R7, R8
      4'hb: r = (arr == lane_cfg_pkg::ARR_FIVE) ? 5'h17 : {1'b1, bitn}; // see R9
      4'hd: r = (arr == lane_cfg_pkg::ARR_FIVE) ? 5'h19 : {1'b1, bitn}; // see R9
      4'hf: r = (arr == lane_cfg_pkg::ARR_FIVE) ? 5'h00 : {1'b1, bitn};
      default: r = 5'h00;
    endcase
    strap_bit_to_port = r;
  endfunction : strap_bit_to_port

  function automatic logic [7:0] rxdet_cycles(input logic [2:0] code);
    unique case (code)
      3'h0: rxdet_cycles = lane_cfg_pkg::RXDET_C0; // see R13
      3'h1: rxdet_cycles = lane_cfg_pkg::RXDET_C1;
      3'h3: rxdet_cycles = lane_cfg_pkg::RXDET_C3;
      3'h4: rxdet_cycles = lane_cfg_pkg::RXDET_C4;
      // Reserved codes fall back to the recommended wait rather than an undefined one.
      default: rxdet_cycles = lane_cfg_pkg::RXDET_C2;
    endcase
  endfunction : rxdet_cycles

  function automatic logic [3:0] eq_clean(input logic [3:0] code);
    unique case (code)
      lane_cfg_pkg::EQ_LOW, lane_cfg_pkg::EQ_MED, lane_cfg_pkg::EQ_HIGH: eq_clean = code; // see R15
      default: eq_clean = lane_cfg_pkg::EQ_OFF;
    endcase
  endfunction : eq_clean

  function automatic logic [1:0] addr_slot(input logic [11:0] addr, output logic hit);
    hit = 1'b1;
    addr_slot = lane_cfg_pkg::SLOT_DEEMPH;
    unique case (addr)
      lane_cfg_pkg::OFF_DEEMPH_BASE: addr_slot = lane_cfg_pkg::SLOT_DEEMPH;
      lane_cfg_pkg::OFF_RX_TX_CTRL: addr_slot = lane_cfg_pkg::SLOT_CTRL;
      lane_cfg_pkg::OFF_AMP_BASE: addr_slot = lane_cfg_pkg::SLOT_AMP;
      lane_cfg_pkg::OFF_DRIVE_OFFSET: addr_slot = lane_cfg_pkg::SLOT_OFFSET;
      default: hit = 1'b0;
    endcase
  endfunction : addr_slot

  // Strap capture: the arrangement is frozen at reset so lanes never change owner under traffic.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      arrangement_q <= port_arrangement_strap; // see R1, R20
      arrangement_reserved_q <= (port_arrangement_strap == lane_cfg_pkg::ARR_RESERVED); // see R1
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port_ok_q <= 16'h0000;
    end else begin
      for (int b = 0; b < lane_cfg_pkg::NUM_PORTS; b++) begin
        logic [4:0] m;
        m = strap_bit_to_port(arrangement_q, 4'(b));
        if (b == 0) begin
          port_ok_q <= 16'h0000;
        end
        if (m[4] && !arrangement_reserved_q) begin
          port_ok_q[m[3:0]] <= !port_ok_strap_n[b]; // see R7, R8, R9
        end
      end
    end
  end

  // Loader access decode.
  logic wr_hit;
  logic rd_hit;
  logic [1:0] wr_slot;
  logic [1:0] rd_slot;
  logic wr_ok;
  always_comb begin
    wr_slot = addr_slot(cfg_addr, wr_hit);
    rd_slot = addr_slot(cfg_addr, rd_hit);
    // Offsets come only from the EEPROM image, other loaders cannot disturb them.
    wr_ok = cfg_wr && wr_hit && ((wr_slot != lane_cfg_pkg::SLOT_OFFSET) || (cfg_src == lane_cfg_pkg::src_eeprom)); // see R18, R11
  end

  logic rd_pend_q;
  logic rd_miss_q;
  logic [31:0] mem_a_data;
  logic [31:0] mem_b_data;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_pend_q <= 1'b0;
      rd_miss_q <= 1'b0;
      cfg_rdata_q <= 32'h0000_0000;
      cfg_rvalid_q <= 1'b0;
      cfg_err_q <= 1'b0;
    end else begin
      rd_pend_q <= cfg_rd && !cfg_wr;
      rd_miss_q <= !rd_hit;
      cfg_rvalid_q <= rd_pend_q;
      cfg_rdata_q <= (rd_pend_q && !rd_miss_q) ? mem_a_data : 32'h0000_0000;
      cfg_err_q <= (cfg_wr && !wr_ok) || (cfg_rd && !cfg_wr && !rd_hit);
    end
  end

  // Lane scanner: walks every lane and slot, copying its port's words into the lane's own set.
  logic [3:0] scan_lane_q;
  logic [1:0] scan_slot_q;
  logic [3:0] cap_lane_q;
  logic [1:0] cap_slot_q;
  logic cap_valid_q;
  logic [31:0] shadow_q [lane_cfg_pkg::NUM_LANES][lane_cfg_pkg::WORDS_PER_PORT];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scan_lane_q <= 4'h0;
      scan_slot_q <= 2'h0;
      cap_lane_q <= 4'h0;
      cap_slot_q <= 2'h0;
      cap_valid_q <= 1'b0;
    end else begin
      scan_slot_q <= scan_slot_q + 2'h1;
      if (scan_slot_q == 2'h3) begin
        scan_lane_q <= (scan_lane_q == 4'(lane_cfg_pkg::NUM_LANES - 1)) ? 4'h0 : scan_lane_q + 4'h1;
      end
      cap_lane_q <= scan_lane_q;
      cap_slot_q <= scan_slot_q;
      cap_valid_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int l = 0; l < lane_cfg_pkg::NUM_LANES; l++) begin
        shadow_q[l][0] <= lane_cfg_pkg::RST_DEEMPH_BASE;
        shadow_q[l][1] <= lane_cfg_pkg::RST_RX_TX_CTRL;
        shadow_q[l][2] <= lane_cfg_pkg::RST_AMP_BASE;
        shadow_q[l][3] <= lane_cfg_pkg::RST_DRIVE_OFFSET;
      end
    end else if (cap_valid_q) begin
      shadow_q[cap_lane_q][cap_slot_q] <= mem_b_data; // see R10
    end
  end

  phy_param_mem u_store (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(wr_ok),
    .wr_addr({cfg_port, wr_slot}),
    .wr_data(cfg_wdata),
    .rd_a_addr({cfg_port, rd_slot}),
    .rd_a_data(mem_a_data),
    .rd_b_addr({lane_to_port(arrangement_q, scan_lane_q), scan_slot_q}),
    .rd_b_data(mem_b_data)
  );

  // Per-lane outputs, each lane from its own copy of its port's settings.
  genvar g;
  generate
    for (g = 0; g < lane_cfg_pkg::NUM_LANES; g++) begin : g_lane
      logic [31:0] ctrl;
      logic [31:0] ampw;
      logic [31:0] dew;
      logic [31:0] offw;
      logic half;
      logic [5:0] amp_base;
      logic [5:0] de_base;
      logic [5:0] amp_sum;
      logic [5:0] de_sum;
      logic [3:0] owner;

      always_comb begin
        ctrl = shadow_q[g][lane_cfg_pkg::SLOT_CTRL];
        ampw = shadow_q[g][lane_cfg_pkg::SLOT_AMP];
        dew = shadow_q[g][lane_cfg_pkg::SLOT_DEEMPH];
        offw = shadow_q[g][lane_cfg_pkg::SLOT_OFFSET];
        owner = lane_to_port(arrangement_q, 4'(g));
        half = ctrl[lane_cfg_pkg::SWING_BIT]; // see R16
        // Full swing takes the -6 dB de-emphasis field (bits 25:21) on lanes with lane_gen2 set, and -3.5 dB (bits 20:16) otherwise.
        amp_base = half ? {1'b0, ampw[lane_cfg_pkg::LVL_LSB_2 +: 5]} : {1'b0, ampw[lane_cfg_pkg::LVL_LSB_0 +: 5]}; // see R17, R12
        de_base = lane_gen2[g] ? {1'b0, dew[lane_cfg_pkg::LVL_LSB_1 +: 5]} : {1'b0, dew[lane_cfg_pkg::LVL_LSB_0 +: 5]}; // see R17, R12
        amp_sum = amp_base + {1'b0, offw[lane_cfg_pkg::AMP_OFF_LSB +: 5]}; // see R19
        de_sum = de_base + {1'b0, offw[lane_cfg_pkg::DEEMPH_OFF_LSB +: 5]}; // see R19
      end

      always_ff @(posedge clk) begin
        if (!reset_n) begin
          pair_enable_q[g] <= 1'b0;
          lane_port_q[g*4 +: 4] <= 4'h0;
          lane_upstream_q[g] <= 1'b0;
        end else begin
          // Lane g drives transmit pair g and listens on receive pair g.
          pair_enable_q[g] <= !arrangement_reserved_q; // see R2
          lane_port_q[g*4 +: 4] <= owner; // see R3, R4, R5
          lane_upstream_q[g] <= !arrangement_reserved_q && (owner == 4'h0); // see R6
        end
      end

      always_ff @(posedge clk) begin
        if (!reset_n) begin
          lane_rxdet_cycles_q[g*8 +: 8] <= lane_cfg_pkg::RXDET_C2;
          lane_sigdet_q[g*2 +: 2] <= 2'h1;
          lane_eq_a_q[g*4 +: 4] <= lane_cfg_pkg::EQ_OFF;
          lane_eq_b_q[g*4 +: 4] <= lane_cfg_pkg::EQ_OFF;
          lane_half_swing_q[g] <= 1'b0;
          lane_amp_q[g*5 +: 5] <= 5'h00;
          lane_deemph_q[g*5 +: 5] <= 5'h00;
        end else begin
          lane_rxdet_cycles_q[g*8 +: 8] <= rxdet_cycles(ctrl[lane_cfg_pkg::RXDET_LSB +: 3]); // see R13
          lane_sigdet_q[g*2 +: 2] <= ctrl[lane_cfg_pkg::SIGDET_LSB +: 2]; // see R14
          lane_eq_a_q[g*4 +: 4] <= eq_clean(ctrl[lane_cfg_pkg::EQ_A_LSB +: 4]); // see R15, R11
          lane_eq_b_q[g*4 +: 4] <= eq_clean(ctrl[lane_cfg_pkg::EQ_B_LSB +: 4]); // see R15
          lane_half_swing_q[g] <= half; // see R16
          // The driver tops out at 475 mV, so the sum saturates instead of wrapping.
          lane_amp_q[g*5 +: 5] <= (amp_sum > lane_cfg_pkg::AMP_MAX_CODE) ?
            lane_cfg_pkg::AMP_MAX_CODE[4:0] : amp_sum[4:0]; // see R19, R11
          // Half swing carries no de-emphasis at all.
          lane_deemph_q[g*5 +: 5] <= half ? 5'h00 :
            ((de_sum > lane_cfg_pkg::DEEMPH_MAX_CODE) ? lane_cfg_pkg::DEEMPH_MAX_CODE[4:0] : de_sum[4:0]); // see R16, R12
        end
      end
    end
  endgenerate

endmodule : pcie_switch_port_lane_config

// ===== core/phy_param_mem.sv
// Per-port parameter store: one write port, two read ports with registered data.
// Assumes the writer and both readers share clk; reset loads the recommended values.
`timescale 1ns/1ps
module phy_param_mem (
  clk,
  reset_n,
  wr_en,
  wr_addr,
  wr_data,
  rd_a_addr,
  rd_a_data,
  rd_b_addr,
  rd_b_data
);
  input wire logic clk;
  input wire logic reset_n;
  input wire logic wr_en;
  input wire logic [lane_cfg_pkg::MEM_AW-1:0] wr_addr;
  input wire logic [31:0] wr_data;
  input wire logic [lane_cfg_pkg::MEM_AW-1:0] rd_a_addr;
  output logic [31:0] rd_a_data;
  input wire logic [lane_cfg_pkg::MEM_AW-1:0] rd_b_addr;
  output logic [31:0] rd_b_data;

  logic [31:0] mem_q [lane_cfg_pkg::MEM_DEPTH];

  function automatic logic [31:0] reset_word(input logic [1:0] slot);
    unique case (slot)
      lane_cfg_pkg::SLOT_DEEMPH: reset_word = lane_cfg_pkg::RST_DEEMPH_BASE;
      lane_cfg_pkg::SLOT_CTRL: reset_word = lane_cfg_pkg::RST_RX_TX_CTRL;
      lane_cfg_pkg::SLOT_AMP: reset_word = lane_cfg_pkg::RST_AMP_BASE;
      lane_cfg_pkg::SLOT_OFFSET: reset_word = lane_cfg_pkg::RST_DRIVE_OFFSET;
    endcase
  endfunction : reset_word

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < lane_cfg_pkg::MEM_DEPTH; i++) begin
        mem_q[i] <= reset_word(2'(i));
      end
    end else if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_a_data <= 32'h0000_0000;
      rd_b_data <= 32'h0000_0000;
    end else begin
      rd_a_data <= mem_q[rd_a_addr];
      rd_b_data <= mem_q[rd_b_addr];
    end
  end

endmodule : phy_param_mem

// ===== tb/cfg_loader_model.sv
// Serial loader model: one register word per request.
// Assumes one caller at a time and the block's clock.
`timescale 1ns/1ps
module cfg_loader_model (
  input wire logic clk,
  input wire logic [31:0] cfg_rdata_q,
  input wire logic cfg_rvalid_q,
  input wire logic cfg_err_q,
  output logic cfg_wr,
  output logic cfg_rd,
  output lane_cfg_pkg::load_src_t cfg_src,
  output logic [3:0] cfg_port,
  output logic [11:0] cfg_addr,
  output logic [31:0] cfg_wdata
);
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_src = lane_cfg_pkg::src_none;
    cfg_port = 4'h0;
    cfg_addr = 12'h0;
    cfg_wdata = 32'h0;
  end
  // Idle lines show garbage: the last port, and the complement of the last address and data.
  task automatic xfer(input logic wr, input lane_cfg_pkg::load_src_t src, input logic [3:0] port,
      input logic [11:0] addr, input logic [31:0] data, output logic [31:0] rdata, output logic rvalid,
      output logic err);
    @(posedge clk);
    cfg_wr <= wr;
    cfg_rd <= !wr;
    cfg_src <= src;
    cfg_port <= port;
    cfg_addr <= addr;
    cfg_wdata <= data;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    cfg_src <= lane_cfg_pkg::src_none;
    cfg_addr <= ~addr;
    cfg_wdata <= ~data;
    #1;
    err = cfg_err_q;
    @(posedge clk);
    #1;
    rvalid = cfg_rvalid_q;
    rdata = cfg_rdata_q;
  endtask : xfer
endmodule : cfg_loader_model

// ===== tb/lane_cfg_checker_assertions.sv
// Concurrent checks on the port and lane configuration block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module lane_cfg_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire lane_cfg_pkg::load_src_t cfg_src,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_rdata_q,
  input wire logic cfg_rvalid_q,
  input wire logic cfg_err_q,
  input wire logic [1:0] arrangement_q,
  input wire logic arrangement_reserved_q,
  input wire logic [11:0] pair_enable_q,
  input wire logic [47:0] lane_port_q,
  input wire logic [11:0] lane_upstream_q,
  input wire logic [95:0] lane_rxdet_cycles_q,
  input wire logic [47:0] lane_eq_a_q,
  input wire logic [11:0] lane_half_swing_q,
  input wire logic [59:0] lane_amp_q,
  input wire logic [59:0] lane_deemph_q
);
  logic [1:0] run_q;
  logic [11:0] up_ok, lvl_ok, eq_ok, rx_ok;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Strap-decoded outputs are judged only once settled; the level, equalizer and rxdet checks run from reset.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      run_q <= 2'h0;
    end else if (run_q != 2'h3) begin
      run_q <= run_q + 2'h1;
    end
  end
  always_comb begin
    for (int n = 0; n < 12; n++) begin
      up_ok[n] = lane_upstream_q[n] == (lane_port_q[4*n+:4] == 4'h0);
      lvl_ok[n] = lane_amp_q[5*n+:5] <= 5'h13 && !(lane_half_swing_q[n] && lane_deemph_q[5*n+:5] != 5'h0);
      eq_ok[n] = lane_eq_a_q[4*n+:4] inside {4'h0, 4'h2, 4'h6, 4'he};
      rx_ok[n] = lane_rxdet_cycles_q[8*n+:8] inside {8'h19, 8'h32, 8'h64, 8'h7d, 8'haf};
    end
  end
  sequence rd_take;
    cfg_rd && !cfg_wr;
  endsequence
  sequence rd_answer;
    ##2 cfg_rvalid_q;
  endsequence
  read_answer_a: assert property (rd_take |-> rd_answer) else $error("read unanswered");
  answer_cause_a: assert property (cfg_rvalid_q |-> $past(cfg_rd, 2) && !$past(cfg_wr, 2))
    else $error("stray read data");
  idle_data_a: assert property (!cfg_rvalid_q |-> cfg_rdata_q == 32'h0) else $error("stale read data");
  offset_refused_a: assert property (cfg_wr && cfg_addr == lane_cfg_pkg::OFF_DRIVE_OFFSET &&
    cfg_src != lane_cfg_pkg::src_eeprom |=> cfg_err_q) else $error("offset write not refused");
  offset_taken_a: assert property (cfg_wr && cfg_addr == lane_cfg_pkg::OFF_DRIVE_OFFSET &&
    cfg_src == lane_cfg_pkg::src_eeprom |=> !cfg_err_q) else $error("offset write refused");
  strap_hold_a: assert property ($past(reset_n) |-> $stable(arrangement_q) && $stable(arrangement_reserved_q))
    else $error("arrangement moved");
  reserved_flag_a: assert property (run_q == 2'h3 |-> arrangement_reserved_q == (arrangement_q == 2'h3))
    else $error("reserved flag wrong");
  pair_enable_a: assert property (run_q == 2'h3 |-> pair_enable_q == (arrangement_reserved_q ? 12'h0 : 12'hfff))
    else $error("pair enables wrong");
  upstream_lane_a: assert property (run_q == 2'h3 && !arrangement_reserved_q |-> &up_ok)
    else $error("upstream flag wrong");
  level_limit_a: assert property (&lvl_ok) else $error("drive level out of range");
  eq_code_a: assert property (&eq_ok) else $error("bad equalizer code");
  rxdet_wait_a: assert property (&rx_ok) else $error("bad rxdet wait");
endmodule : lane_cfg_checker

bind pcie_switch_port_lane_config lane_cfg_checker chk (.*);

// ===== tb/pcie_switch_port_lane_config_tb.sv
// Self-checking bench for the port and lane configuration block.
// Assumes the loader model owns the register bus.
`timescale 1ns/1ps
module pcie_switch_port_lane_config_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] strap = 2'h0;
  logic [15:0] ok_n = 16'h0;
  logic [11:0] gen2 = 12'h0;
  logic [31:0] seed = 32'h19;
  logic cfg_wr, cfg_rd, cfg_rvalid_q, cfg_err_q, arrangement_reserved_q;
  lane_cfg_pkg::load_src_t cfg_src;
  logic [3:0] cfg_port;
  logic [11:0] cfg_addr, pair_enable_q, lane_upstream_q, lane_half_swing_q;
  logic [31:0] cfg_wdata, cfg_rdata_q;
  logic [1:0] arrangement_q;
  logic [15:0] port_ok_q;
  logic [47:0] lane_port_q, lane_eq_a_q, lane_eq_b_q;
  logic [95:0] lane_rxdet_cycles_q;
  logic [23:0] lane_sigdet_q;
  logic [59:0] lane_amp_q, lane_deemph_q;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  pcie_switch_port_lane_config dut (.port_arrangement_strap(strap), .port_ok_strap_n(ok_n), .lane_gen2(gen2), .*);
  cfg_loader_model ld (.*);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Owner port per lane, lane n in bits 4n+3:4n.
  function automatic logic [47:0] lane_map(input logic [1:0] c);
    case (c)
      2'h0: return 48'hfdb3eca20000;
      2'h1: return 48'hfdb322220000;
      2'h2: return 48'h993377220000;
      default: return 48'h0;
    endcase
  endfunction : lane_map
  function automatic logic [15:0] exp_ok(input logic [1:0] c, input logic [15:0] n);
    logic [15:0] g;
    g = ~n;
    case (c)
      2'h0: return g & 16'hfc0d;
      2'h1: return g & 16'ha80d;
      2'h2: return (g & 16'h000d) | {6'h0, g[13], 1'b0, g[11], 7'h0};
      default: return 16'h0;
    endcase
  endfunction : exp_ok
  function automatic logic [7:0] rx_cyc(input logic [2:0] code);
    case (code)
      3'h0: return 8'h19;
      3'h1: return 8'h32;
      3'h3: return 8'h7d;
      3'h4: return 8'haf;
      default: return 8'h64;
    endcase
  endfunction : rx_cyc
  function automatic logic [3:0] eqf(input logic [3:0] x);
    return (x inside {4'h0, 4'h2, 4'h6, 4'he}) ? x : 4'h0;
  endfunction : eqf
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  task automatic lane_check(input logic [3:0] p, input logic [31:0] ctl, amp, dm, off);
    logic [5:0] a;
    logic [5:0] d;
    for (int n = 0; n < 12; n++) begin
      if (((lane_map(2'h2) >> (4 * n)) & 48'hf) == 48'(p)) begin
        a = 6'(ctl[30] ? amp[30:26] : amp[20:16]) + 6'(off[4:0]);
        d = ctl[30] ? 6'h0 : 6'(gen2[n] ? dm[25:21] : dm[20:16]) + 6'(off[12:8]);
        check(lane_rxdet_cycles_q[8*n+:8], rx_cyc(ctl[6:4]), "rxdet");
        check(lane_sigdet_q[2*n+:2], ctl[21:20], "sigdet");
        check({lane_eq_b_q[4*n+:4], lane_eq_a_q[4*n+:4]}, {eqf(ctl[29:26]), eqf(ctl[25:22])}, "eq");
        check(lane_half_swing_q[n], ctl[30], "swing");
        check(lane_amp_q[5*n+:5], a > 6'h13 ? 6'h13 : a, "amp");
        check(lane_deemph_q[5*n+:5], d > 6'h1f ? 6'h1f : d, "deemph");
      end
    end
  endtask : lane_check
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    logic [31:0] d, ctl, amp, dm, off;
    logic v, e;
    logic [3:0] p;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i + 3);
      @(posedge clk);
      reset_n <= 1'b0;
      strap <= c;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      strap <= ~c;
      ok_n <= i == 1 ? 16'h0 : 16'(rnd());
      repeat (3) @(posedge clk);
      #1;
      check(arrangement_q, c, "arrangement");
      check(arrangement_reserved_q, c == 2'h3, "reserved");
      check(lane_port_q, lane_map(c), "lane owners");
      check(pair_enable_q, c == 2'h3 ? 12'h0 : 12'hfff, "pairs");
      if (c != 2'h3) check(lane_upstream_q, 12'h00f, "upstream");
      check(port_ok_q, exp_ok(c, ok_n), "port good");
      $display("strap mode %0d done", c);
    end
    p = 4'(rnd());
    ld.xfer(1'b0, lane_cfg_pkg::src_i2c, p, lane_cfg_pkg::OFF_RX_TX_CTRL, 32'h0, d, v, e);
    check({v, d}, {1'b1, lane_cfg_pkg::RST_RX_TX_CTRL}, "ctl reset");
    lane_check(4'h0, lane_cfg_pkg::RST_RX_TX_CTRL, 32'h0, 32'h0, 32'h0);
    ld.xfer(1'b0, lane_cfg_pkg::src_smbus, p, 12'h85c, 32'h0, d, v, e);
    check({e, v, d}, {2'h3, 32'h0}, "unmapped read");
    $display("reset values done");
    for (int k = 0; k < 12; k++) begin
      p = lane_map(2'h2) >> (4 * k) & 48'hf;
      ctl = rnd();
      ctl[6:4] = 3'(k);
      if (k < 4) ctl[29:22] = {4'(16'he620 >> (4 * (3 - k))), 4'(16'he620 >> (4 * k))};
      amp = rnd();
      dm = rnd();
      off = k == 0 ? 32'h1f1f : rnd();
      @(posedge clk);
      gen2 <= 12'(rnd());
      ld.xfer(1'b1, lane_cfg_pkg::load_src_t'(2'(k % 3)), p, lane_cfg_pkg::OFF_RX_TX_CTRL, ctl, d, v, e);
      check({e, v}, 2'h0, "ctl write");
      ld.xfer(1'b1, lane_cfg_pkg::src_eeprom, p, lane_cfg_pkg::OFF_AMP_BASE, amp, d, v, e);
      ld.xfer(1'b1, lane_cfg_pkg::src_i2c, p, lane_cfg_pkg::OFF_DEEMPH_BASE, dm, d, v, e);
      ld.xfer(1'b1, lane_cfg_pkg::src_eeprom, p, lane_cfg_pkg::OFF_DRIVE_OFFSET, off, d, v, e);
      check(e, 1'b0, "offset ok");
      ld.xfer(1'b1, lane_cfg_pkg::load_src_t'(2'(k % 3 + 1)), p, lane_cfg_pkg::OFF_DRIVE_OFFSET, ~off, d, v, e);
      check(e, 1'b1, "offset refused");
      ld.xfer(1'b0, lane_cfg_pkg::src_smbus, p, lane_cfg_pkg::OFF_DRIVE_OFFSET, 32'h0, d, v, e);
      check(d & 32'h1f1f, off & 32'h1f1f, "offset kept");
      ld.xfer(1'b0, lane_cfg_pkg::src_eeprom, p, lane_cfg_pkg::OFF_RX_TX_CTRL, 32'h0, d, v, e);
      check(d, ctl, "ctl readback");
      // Lane outputs trail the store by one full scan.
      repeat (52) @(posedge clk);
      #1;
      lane_check(p, ctl, amp, dm, off);
      $display("parameter pass %0d done", k);
    end
    conclude();
  end
endmodule : pcie_switch_port_lane_config_tb
